// ==== hdl/tcr_pkg.sv ====
// Purpose: shared constants and carriers for the temperature cycle result block
// Assumes: one clock, synchronous active-low reset
// Notes: register addresses are the read-only word addresses of the device map
`default_nettype none
package tcr_pkg;
  localparam logic [7:0] ADDR_PORT4_FRAC = 8'hee;
  localparam logic [7:0] ADDR_CYCLE_COUNT = 8'hef;
  localparam logic [15:0] FRAC_RESET = 16'h0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [14:0] AVG_INT_RESET = 15'h0000;
  localparam logic [15:0] AVG_FRAC_RESET = 16'h0000;
  localparam logic [15:0] READ_RESET = 16'h0000;

  // per-cycle result of one port: 15-bit periods, 16-bit fraction
  typedef struct packed {
    logic [14:0] int_part;
    logic [15:0] frac_part;
  } tcr_time_t;

  // one averaged port result
  typedef struct packed {
    logic [14:0] avg_int;
    logic [15:0] avg_frac;
  } tcr_avg_t;

  typedef enum logic [1:0] {
    TCR_IDLE,
    TCR_DIVIDE,
    TCR_DONE
  } tcr_state_t;
endpackage
`default_nettype wire

// ==== hdl/tcr_result_regs.sv ====
// Purpose: port-four fraction, temperature cycle counter and per-port averaging
// Assumes: sequencer supplies per-cycle pulses synchronous to sys_clk_in
// Notes: averages use a restoring divider, one quotient bit per clock
// Notes: a zero counter gives zero averages
// Contract
// - a 16-bit read-only fraction holds the port-four capacitor charge time.
// - the fraction is one clock period in 16-bit binary steps, all ones being just under one.
// - the cycle counter is an unsigned 8-bit value readable by software.
// - only valid error-free cycles of the first or third event sequence are counted.
// - each error-free temperature command adds one; cycles with errors leave it alone.
// - the counter is the divisor used to form each port's averaged results.
// - finishing the configured cycles sets the done flag and an enabled low-true interrupt.
// - each averaged integer is the port sum over the counter, in whole periods, 15 bits at most.
`default_nettype none
module tcr_result_regs #(
  parameter int PORTS = 4,
  parameter int CYC_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic seq_first_active_in,
  input wire logic seq_third_active_in,
  input wire logic temp_cycle_end_in,
  input wire logic temp_cycle_error_in,
  input wire tcr_pkg::tcr_time_t [PORTS-1:0] port_time_in,
  input wire logic seq_start_in,
  input wire logic [CYC_W-1:0] cycles_configured_in,
  input wire logic temp_done_irq_en_in,
  input wire logic temp_done_clear_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  output logic rd_hit_out,
  output logic [CYC_W-1:0] cycle_count_out,
  output tcr_pkg::tcr_avg_t [PORTS-1:0] port_avg_out,
  output logic avg_valid_out,
  output logic temp_sequence_done_flag_out,
  output logic irq_n_out
);
  localparam int SUM_W = 31 + CYC_W;
  localparam int QB = 31;

  typedef struct packed {
    logic [15:0] frac;
    logic [CYC_W-1:0] count;
    logic [CYC_W-1:0] tried;
    logic [PORTS-1:0][SUM_W-1:0] sum;
    logic [PORTS-1:0][SUM_W-1:0] rem;
    logic [PORTS-1:0][30:0] quo;
    tcr_pkg::tcr_avg_t [PORTS-1:0] avg;
    logic [5:0] bit_idx;
    tcr_pkg::tcr_state_t state;
    logic done_flag;
    logic avg_valid;
    logic [15:0] rd_data;
  } tcr_state_all_t;

  tcr_state_all_t st_r, st_nxt;
  logic seq_ok;
  logic cycle_good;
  logic cycle_any;
  logic [SUM_W-1:0] divisor;
  logic [PORTS-1:0][SUM_W-1:0] step_rem;
  logic [PORTS-1:0] step_bit;

  // ************************************************
  // per-port divide steps
  // ************************************************
  assign divisor = SUM_W'(st_r.count);
  for (genvar g = 0; g < PORTS; g++) begin : g_div
    tcr_div_step #(
      .SUM_W(SUM_W),
      .QB(QB)
    ) u_step (
      .sum_in(st_r.sum[g]),
      .rem_in(st_r.rem[g]),
      .divisor_in(divisor),
      .bit_idx_in(st_r.bit_idx),
      .rem_out(step_rem[g]),
      .quo_bit_out(step_bit[g])
    );
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_nxt = st_r;
    seq_ok = seq_first_active_in | seq_third_active_in;
    cycle_any = temp_cycle_end_in & seq_ok;
    cycle_good = cycle_any & ~temp_cycle_error_in;
    // a start pulse outranks any event in the same cycle
    if (seq_start_in) begin
      st_nxt.count = tcr_pkg::COUNT_RESET;
      st_nxt.tried = '0;
      st_nxt.sum = '0;
      st_nxt.avg_valid = 1'b0;
      st_nxt.state = tcr_pkg::TCR_IDLE;
    end else begin
      if (cycle_any) begin
        st_nxt.tried = st_r.tried + CYC_W'(1);
        // fraction of port four latched each completed cycle
        st_nxt.frac = port_time_in[3 % PORTS].frac_part;
      end
      if (cycle_good) begin
        st_nxt.count = st_r.count + CYC_W'(1);
        for (int p = 0; p < PORTS; p++) begin
          st_nxt.sum[p] = st_r.sum[p] + SUM_W'(port_time_in[p]);
        end
      end
      unique case (st_r.state)
        tcr_pkg::TCR_IDLE: begin
          // completion counts attempted cycles, errored ones included
          if (cycle_any && (st_r.tried + CYC_W'(1) == cycles_configured_in)) begin
            st_nxt.state = tcr_pkg::TCR_DIVIDE;
            st_nxt.bit_idx = 6'(QB - 1);
          end
        end
        tcr_pkg::TCR_DIVIDE: begin
          // every port steps at once against the shared counter
          for (int p = 0; p < PORTS; p++) begin
            st_nxt.rem[p] = step_rem[p];
            st_nxt.quo[p][st_r.bit_idx[4:0]] = step_bit[p];
          end
          if (st_r.bit_idx == 6'h00) begin
            st_nxt.state = tcr_pkg::TCR_DONE;
          end else begin
            st_nxt.bit_idx = st_r.bit_idx - 6'h01;
          end
        end
        tcr_pkg::TCR_DONE: begin
          for (int p = 0; p < PORTS; p++) begin
            st_nxt.avg[p].avg_int = st_r.quo[p][30:16];
            st_nxt.avg[p].avg_frac = st_r.quo[p][15:0];
          end
          st_nxt.avg_valid = 1'b1;
          st_nxt.done_flag = 1'b1;
          st_nxt.state = tcr_pkg::TCR_IDLE;
        end
      endcase
    end
    // a flag set in this cycle outranks the clear
    if (temp_done_clear_in && !(st_r.state == tcr_pkg::TCR_DONE)) begin
      st_nxt.done_flag = 1'b0;
    end
    // read data reflects this edge's updates
    st_nxt.rd_data = tcr_pkg::READ_RESET;
    if (rd_en_in) begin
      if (rd_addr_in == tcr_pkg::ADDR_PORT4_FRAC) begin
        st_nxt.rd_data = st_nxt.frac;
      end else if (rd_addr_in == tcr_pkg::ADDR_CYCLE_COUNT) begin
        st_nxt.rd_data = 16'(st_nxt.count);
      end
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.frac <= tcr_pkg::FRAC_RESET;
      st_r.count <= tcr_pkg::COUNT_RESET;
      st_r.state <= tcr_pkg::TCR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign rd_data_out = st_r.rd_data;
  assign rd_hit_out = rd_en_in &&
    (rd_addr_in == tcr_pkg::ADDR_PORT4_FRAC || rd_addr_in == tcr_pkg::ADDR_CYCLE_COUNT);
  assign cycle_count_out = st_r.count;
  assign port_avg_out = st_r.avg;
  assign avg_valid_out = st_r.avg_valid;
  assign temp_sequence_done_flag_out = st_r.done_flag;
  // interrupt follows the enable without waiting for a clock
  assign irq_n_out = ~(st_r.done_flag & temp_done_irq_en_in);
endmodule

// ************************************************
// one restoring-divide step
// ************************************************
module tcr_div_step #(
  parameter int SUM_W = 39,
  parameter int QB = 31
) (
  input wire logic [SUM_W-1:0] sum_in,
  input wire logic [SUM_W-1:0] rem_in,
  input wire logic [SUM_W-1:0] divisor_in,
  input wire logic [5:0] bit_idx_in,
  output logic [SUM_W-1:0] rem_out,
  output logic quo_bit_out
);
  logic [SUM_W-1:0] trial;

  always_comb begin
    // first step brings down every dividend bit from the top quotient bit's position up
    if (bit_idx_in == 6'(QB - 1)) begin
      trial = SUM_W'(sum_in >> (QB - 1));
    end else begin
      trial = {rem_in[SUM_W-2:0], sum_in[bit_idx_in[4:0]]};
    end
    // zero divisor keeps the quotient bit clear
    if (divisor_in != '0 && trial >= divisor_in) begin
      rem_out = trial - divisor_in;
      quo_bit_out = 1'b1;
    end else begin
      rem_out = trial;
      quo_bit_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tcr_chk_assertions.sv ====
// Purpose: port checks of the cycle result block
// Assumes: bound to tcr_result_regs
// Notes: counter width follows the bound instance
`default_nettype none
module tcr_chk #(
  parameter int CYC_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic seq_first_active_in,
  input wire logic seq_third_active_in,
  input wire logic temp_cycle_end_in,
  input wire logic temp_cycle_error_in,
  input wire logic seq_start_in,
  input wire logic temp_done_irq_en_in,
  input wire logic temp_done_clear_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_hit_out,
  input wire logic [CYC_W-1:0] cycle_count_out,
  input wire logic temp_sequence_done_flag_out,
  input wire logic irq_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic good;
  assign good = temp_cycle_end_in && !temp_cycle_error_in && !seq_start_in
    && (seq_first_active_in || seq_third_active_in);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_hit_decode: assert property (rd_hit_out == (rd_en_in && rd_addr_in[7:1] == 7'h77))
    else $error("bad hit");
  a_miss_zero: assert property (!rd_hit_out |=> rd_data_out == 16'h0000)
    else $error("bad idle data");
  a_count_read: assert property (
    rd_en_in && rd_addr_in == 8'hef |=> rd_data_out[7:0] == cycle_count_out)
    else $error("bad count read");
  a_good_incr: assert property (good |=> cycle_count_out == $past(cycle_count_out) + 8'h01)
    else $error("no increment");
  a_err_hold: assert property (!good && !seq_start_in |=> $stable(cycle_count_out))
    else $error("count moved");
  a_start_clear: assert property (seq_start_in |=> cycle_count_out == '0)
    else $error("count not cleared");
  a_irq_level: assert property (
    irq_n_out == !(temp_sequence_done_flag_out && temp_done_irq_en_in))
    else $error("bad irq");
  a_flag_sticky: assert property (
    temp_sequence_done_flag_out && !temp_done_clear_in |=> temp_sequence_done_flag_out)
    else $error("flag lost");
endmodule
bind tcr_result_regs tcr_chk #(
  .CYC_W(CYC_W)
) u_chk (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .seq_first_active_in(seq_first_active_in),
  .seq_third_active_in(seq_third_active_in),
  .temp_cycle_end_in(temp_cycle_end_in),
  .temp_cycle_error_in(temp_cycle_error_in),
  .seq_start_in(seq_start_in),
  .temp_done_irq_en_in(temp_done_irq_en_in),
  .temp_done_clear_in(temp_done_clear_in),
  .rd_addr_in(rd_addr_in),
  .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out),
  .rd_hit_out(rd_hit_out),
  .cycle_count_out(cycle_count_out),
  .temp_sequence_done_flag_out(temp_sequence_done_flag_out),
  .irq_n_out(irq_n_out)
);
`default_nettype wire

// ==== bench/tcr_host.sv ====
// Purpose: host reading the result registers
// Assumes: strobe taken on the rising edge
// Notes: address shows the inverse when idle
`default_nettype none
module tcr_host (
  input wire logic sys_clk_in,
  output logic rd_en_out,
  output logic [7:0] rd_addr_out,
  input wire logic [15:0] rd_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_en_out = 1'b0;
    rd_addr_out = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk_in);
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(negedge sys_clk_in);
    d = rd_data_in;
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench of tcr_result_regs
// Assumes: 200 MHz clock, inputs change on falling edges
// Notes: row bits are first, third, error, increment
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 0, rst_n_in = 0, seq_first_active_in = 0, seq_third_active_in = 0;
  logic temp_cycle_end_in = 0, temp_cycle_error_in = 0, seq_start_in = 0;
  logic temp_done_irq_en_in = 0, temp_done_clear_in = 0, rd_en_in, rd_hit_out;
  logic avg_valid_out, temp_sequence_done_flag_out, irq_n_out;
  logic [7:0] cycles_configured_in = 8'hff, rd_addr_in, cycle_count_out, exp;
  logic [15:0] rd_data_out, d;
  tcr_pkg::tcr_time_t t = '0;
  tcr_pkg::tcr_time_t [3:0] port_time_in;
  tcr_pkg::tcr_avg_t [3:0] port_avg_out;
  logic [3:0] rows [6] = '{4'h9, 4'h5, 4'h6, 4'h0, 4'hd, 4'ha};
  int error_cnt = 0, n_tests = 0;
  logic timed_out = 1'b0;
  assign port_time_in = {4{t}};
  always #2.5 sys_clk_in = ~sys_clk_in;
  tcr_result_regs u_dut (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .seq_first_active_in(seq_first_active_in),
    .seq_third_active_in(seq_third_active_in),
    .temp_cycle_end_in(temp_cycle_end_in),
    .temp_cycle_error_in(temp_cycle_error_in),
    .port_time_in(port_time_in),
    .seq_start_in(seq_start_in),
    .cycles_configured_in(cycles_configured_in),
    .temp_done_irq_en_in(temp_done_irq_en_in),
    .temp_done_clear_in(temp_done_clear_in),
    .rd_addr_in(rd_addr_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .rd_hit_out(rd_hit_out),
    .cycle_count_out(cycle_count_out),
    .port_avg_out(port_avg_out),
    .avg_valid_out(avg_valid_out),
    .temp_sequence_done_flag_out(temp_sequence_done_flag_out),
    .irq_n_out(irq_n_out)
  );
  tcr_host u_host (.sys_clk_in(sys_clk_in), .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in),
    .rd_data_in(rd_data_out));
  task automatic pulse(ref logic s);
    @(negedge sys_clk_in);
    s = 1'b1;
    @(negedge sys_clk_in);
    s = 1'b0;
  endtask
  task automatic ev(input logic [2:0] fte, input tcr_pkg::tcr_time_t v);
    {seq_first_active_in, seq_third_active_in, temp_cycle_error_in} = fte;
    t = v;
    pulse(temp_cycle_end_in);
  endtask
  task automatic wait_flag();
    int n;
    for (n = 0; n < 60 && temp_sequence_done_flag_out !== 1'b1; n++) begin
      @(negedge sys_clk_in);
    end
    if (n == 60) begin
      error_cnt++;
      timed_out = 1'b1;
      $display("unexpected at %0t: done flag timeout", $time);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    `CHK(cycle_count_out, 8'h00)
    `CHK(irq_n_out, 1'b1)
    pulse(seq_start_in);
    exp = 8'h00;
    foreach (rows[k]) begin
      ev(rows[k][3:1], '0);
      exp += {7'h00, rows[k][0]};
      `CHK(cycle_count_out, exp)
    end
    u_host.rd(8'hef, d);
    `CHK(d[7:0], exp)
    u_host.rd(8'hed, d);
    `CHK(d, 16'h0000)
    cycles_configured_in = 8'h03;
    temp_done_irq_en_in = 1'b1;
    pulse(seq_start_in);
    ev(3'b100, {15'h0003, 16'h0000});
    ev(3'b101, {15'h0007, 16'h0001});
    ev(3'b010, {15'h0005, 16'hffff});
    wait_flag();
    if (!timed_out) begin
      `CHK(irq_n_out, 1'b0)
      `CHK(avg_valid_out, 1'b1)
      temp_done_irq_en_in = 1'b0;
      #1 `CHK(irq_n_out, 1'b1)
      `CHK(port_avg_out[3], {15'h0004, 16'h7fff})
      u_host.rd(8'hee, d);
      `CHK(d, 16'hffff)
      u_host.rd(8'hef, d);
      `CHK(d[7:0], 8'h02)
      pulse(temp_done_clear_in);
      `CHK(temp_sequence_done_flag_out, 1'b0)
      // every cycle errored: zero counter, zero averages
      cycles_configured_in = 8'h01;
      pulse(seq_start_in);
      `CHK(avg_valid_out, 1'b0)
      ev(3'b101, {15'h0002, 16'h0003});
      wait_flag();
    end
    if (!timed_out) begin
      `CHK(cycle_count_out, 8'h00)
      `CHK(port_avg_out[0], {15'h0000, 16'h0000})
      // mid-run reset
      temp_done_irq_en_in = 1'b1;
      @(negedge sys_clk_in);
      `CHK(irq_n_out, 1'b0)
      rst_n_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      `CHK(temp_sequence_done_flag_out, 1'b0)
      `CHK(irq_n_out, 1'b1)
      `CHK(avg_valid_out, 1'b0)
      rst_n_in = 1'b1;
      u_host.rd(8'hee, d);
      `CHK(d, 16'h0000)
    end
    conclude();
  end
endmodule
`default_nettype wire
